// ---- hdl/nfh_host.sv ----
/*
  host bus controller for an asynchronous parallel nor flash: random and page reads,
  command writes with suspend filtering, hardware reset with recovery wait.
  assumes the flash ready/busy pin is open drain and the data lines are two-way.
*/
// Overview of operation
// - page taken from upper address bits, word from low bits; only low bits change
// - chip select held low across page reads; raising it forces random latency
// - host keeps a minimum gap from resume to the next suspend
// - hardware reset aborts routines; host waits recovery before new access
module nfh_host #(
  parameter int RECOV_CYCLES   = nfh_pkg::RECOV_CYC,
  parameter int SUSPEND_GAP    = 5000
) (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  // user command port
  input  wire logic                       req_valid_i,
  output logic                            req_ready_o,
  input  wire logic [1:0]                 req_op_i,
  input  wire logic [nfh_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [nfh_pkg::DATA_W-1:0] req_wdata_i,
  input  wire logic                       prog_running_i,
  input  wire logic                       erase_running_i,
  output logic                            rsp_valid_o,
  output logic [nfh_pkg::DATA_W-1:0]      rsp_rdata_o,
  output logic                            rsp_dropped_o,
  output logic                            busy_o,
  // flash pins
  output logic [nfh_pkg::ADDR_W-1:0]      fl_addr_o,
  output logic                            fl_ce_n_o,
  output logic                            fl_oe_n_o,
  output logic                            fl_we_n_o,
  output logic                            fl_reset_n_o,
  input  wire logic [nfh_pkg::DATA_W-1:0] fl_dq_i,
  output logic [nfh_pkg::DATA_W-1:0]      fl_dq_o,
  output logic                            fl_dq_oe_o,
  input  wire logic                       fl_ready_i
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    nfh_pkg::nfh_state_t                st;
    logic [nfh_pkg::CNT_W-1:0]          cnt;
    logic [15:0]                        gap;
    logic                               page_ok;
    logic [nfh_pkg::ADDR_W-1:0]         addr;
    logic [nfh_pkg::DATA_W-1:0]         wdata;
    logic [nfh_pkg::DATA_W-1:0]         rdata;
    logic                               rvalid;
    logic                               dropped;
    logic                               ce_n;
    logic                               oe_n;
    logic                               we_n;
    logic                               rst_n;
    logic                               dq_oe;
    logic [2:0]                         rdy_sync;
    logic                               rdy;
  } nfh_regs_t;

  nfh_regs_t r;
  nfh_regs_t next_r;
  logic      same_page;
  logic      cmd_ok;
  logic      is_suspend;
  logic [7:0] code;

  assign code       = req_wdata_i[7:0];
  // page compare on upper bits only; the low bits pick the word
  assign same_page  = r.page_ok &&
                      (req_addr_i[nfh_pkg::ADDR_W-1:nfh_pkg::WORD_BITS] ==
                       r.addr[nfh_pkg::ADDR_W-1:nfh_pkg::WORD_BITS]);
  assign is_suspend = (code == nfh_pkg::CMD_PROG_SUSPEND) ||
                      (code == nfh_pkg::CMD_ANY_SUSPEND) ||
                      (code == nfh_pkg::CMD_ERASE_SUSPEND);

  // filter commands the flash would ignore while a routine runs
  always_comb begin
    cmd_ok = 1'b1;
    if (prog_running_i) begin
      cmd_ok = (code == nfh_pkg::CMD_PROG_SUSPEND) || (code == nfh_pkg::CMD_STATUS_READ) ||
               (code == nfh_pkg::CMD_ANY_SUSPEND);
    end else if (erase_running_i) begin
      cmd_ok = (code == nfh_pkg::CMD_STATUS_READ) ||
               (code == nfh_pkg::CMD_ERASE_SUSPEND);
    end
    // refuse (drop) a suspend while the resume gap is still running
    if (is_suspend && (r.gap != 16'h0000)) begin
      cmd_ok = 1'b0;
    end
  end

  assign req_ready_o = (r.st == nfh_pkg::NFH_ST_IDLE);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_r          = r;
    next_r.rvalid   = 1'b0;
    next_r.dropped  = 1'b0;
    next_r.rdy_sync = {r.rdy_sync[1:0], fl_ready_i};
    if (r.rdy_sync[2] == r.rdy_sync[1]) begin
      next_r.rdy = r.rdy_sync[1];
    end
    if (r.gap != 16'h0000) begin
      next_r.gap = r.gap - 16'h0001;
    end
    case (r.st)
      nfh_pkg::NFH_ST_IDLE: begin
        next_r.oe_n  = 1'b1;
        next_r.dq_oe = 1'b0;
        if (req_valid_i) begin
          next_r.addr  = req_addr_i;
          next_r.wdata = req_wdata_i;
          case (req_op_i)
            nfh_pkg::NFH_OP_READ: begin
              next_r.st   = nfh_pkg::NFH_ST_READ;
              next_r.ce_n = 1'b0;
              next_r.oe_n = 1'b0;
              // page hit keeps chip select low and waits page time
              next_r.cnt  = same_page ? nfh_pkg::CNT_W'(nfh_pkg::PAGE_CYC)
                                      : nfh_pkg::CNT_W'(nfh_pkg::RANDOM_CYC);
            end
            nfh_pkg::NFH_OP_WRITE: begin
              if (cmd_ok) begin
                next_r.st      = nfh_pkg::NFH_ST_WRITE;
                next_r.ce_n    = 1'b0;
                next_r.we_n    = 1'b0;
                next_r.dq_oe   = 1'b1;
                next_r.page_ok = 1'b0;
                next_r.cnt     = nfh_pkg::CNT_W'(nfh_pkg::WRP_CYC);
                if (!is_suspend && (prog_running_i || erase_running_i)) begin
                  next_r.gap = r.gap;
                end else if (!is_suspend) begin
                  next_r.gap = 16'(SUSPEND_GAP);
                end
              end else begin
                next_r.dropped = 1'b1;
              end
            end
            nfh_pkg::NFH_OP_RESET: begin
              next_r.st      = nfh_pkg::NFH_ST_RST;
              next_r.rst_n   = 1'b0;
              next_r.ce_n    = 1'b1;
              next_r.page_ok = 1'b0;
              next_r.cnt     = nfh_pkg::CNT_W'(nfh_pkg::RSTP_CYC);
            end
            default: next_r.dropped = 1'b1;
          endcase
        end
      end
      nfh_pkg::NFH_ST_READ: begin
        next_r.cnt = r.cnt - 1'b1;
        if (r.cnt == 1) begin
          next_r.rdata   = fl_dq_i;
          next_r.rvalid  = 1'b1;
          next_r.page_ok = 1'b1;
          next_r.st      = nfh_pkg::NFH_ST_IDLE;
        end
      end
      nfh_pkg::NFH_ST_WRITE: begin
        next_r.cnt = r.cnt - 1'b1;
        if (r.cnt == 1) begin
          next_r.we_n = 1'b1;
          next_r.st   = nfh_pkg::NFH_ST_WHOLD;
        end
      end
      nfh_pkg::NFH_ST_WHOLD: begin
        next_r.ce_n  = 1'b1;
        next_r.dq_oe = 1'b0;
        next_r.st    = nfh_pkg::NFH_ST_IDLE;
      end
      nfh_pkg::NFH_ST_RST: begin
        next_r.cnt = r.cnt - 1'b1;
        if (r.cnt == 1) begin
          next_r.rst_n = 1'b1;
          next_r.cnt   = nfh_pkg::CNT_W'(RECOV_CYCLES);
          next_r.st    = nfh_pkg::NFH_ST_RECOV;
        end
      end
      nfh_pkg::NFH_ST_RECOV: begin
        // no access until the recovery time has passed
        next_r.cnt = r.cnt - 1'b1;
        if (r.cnt == 1) begin
          next_r.gap = 16'h0000;
          next_r.st  = nfh_pkg::NFH_ST_IDLE;
        end
      end
      default: next_r.st = nfh_pkg::NFH_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r          <= '0;
      r.st       <= nfh_pkg::NFH_ST_IDLE;
      r.ce_n     <= 1'b1;
      r.oe_n     <= 1'b1;
      r.we_n     <= 1'b1;
      r.rst_n    <= 1'b1;
      r.rdy_sync <= 3'b111;
      r.rdy      <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rsp_valid_o   = r.rvalid;
  assign rsp_rdata_o   = r.rdata;
  assign rsp_dropped_o = r.dropped;
  assign busy_o        = ~r.rdy;
  assign fl_addr_o     = r.addr;
  assign fl_ce_n_o     = r.ce_n;
  assign fl_oe_n_o     = r.oe_n;
  assign fl_we_n_o     = r.we_n;
  assign fl_reset_n_o  = r.rst_n;
  assign fl_dq_o       = r.wdata;
  assign fl_dq_oe_o    = r.dq_oe;
endmodule

// ---- hdl/nfh_pkg.sv ----
/*
  package for the nor flash host controller: bus widths, page layout, timing counts,
  command codes and controller states.
  assumes a 10 MHz reference clock; command codes are plain parameters of neutral value.
*/
package nfh_pkg;
  // ************************************************************
  // widths and page layout
  // ************************************************************
  localparam int ADDR_W       = 26;
  localparam int DATA_W       = 16;
  localparam int WORD_BITS    = 4;
  localparam int WIP_LSB      = 0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS          = 100;
  localparam int RANDOM_ACCESS_TIME_NS  = 100;
  localparam int PAGE_ACCESS_TIME_NS    = 15;
  localparam int RESET_RECOVERY_TIME_NS = 30000;
  localparam int RESET_PULSE_TIME_NS    = 500;
  localparam int WRITE_PULSE_TIME_NS    = 100;
  localparam int RANDOM_CYC = (RANDOM_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int PAGE_CYC   = (PAGE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int RECOV_CYC  = (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RSTP_CYC   = (RESET_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRP_CYC    = (WRITE_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 16;

  // ************************************************************
  // command codes (suspend and status read)
  // ************************************************************
  localparam logic [7:0] CMD_PROG_SUSPEND  = 8'h51;
  localparam logic [7:0] CMD_STATUS_READ   = 8'h70;
  localparam logic [7:0] CMD_ANY_SUSPEND   = 8'hB0;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'h80;

  // ************************************************************
  // operation kinds on the command port
  // ************************************************************
  typedef enum logic [1:0] {
    NFH_OP_READ  = 2'b00,
    NFH_OP_WRITE = 2'b01,
    NFH_OP_RESET = 2'b10
  } nfh_op_t;

  typedef enum logic [2:0] {
    NFH_ST_IDLE  = 3'b000,
    NFH_ST_READ  = 3'b001,
    NFH_ST_WRITE = 3'b010,
    NFH_ST_WHOLD = 3'b011,
    NFH_ST_RST   = 3'b100,
    NFH_ST_RECOV = 3'b101
  } nfh_state_t;
endpackage

// ---- dv/nfh_host_chk.sv ----
/* checker for nfh_host: read latency, pin timing, command filtering, reset pulse, busy.
   assumes it is bound to nfh_host and sees only its ports. */
module nfh_host_chk (
  // clock and reset
  input wire logic                       ref_clk_i,
  input wire logic                       rst_i,
  // command port
  input wire logic                       req_valid_i,
  input wire logic                       req_ready_o,
  input wire logic [1:0]                 req_op_i,
  input wire logic [nfh_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic                       prog_running_i,
  input wire logic                       erase_running_i,
  input wire logic                       rsp_valid_o,
  input wire logic                       rsp_dropped_o,
  input wire logic                       busy_o,
  // flash pins
  input wire logic                       fl_ce_n_o,
  input wire logic                       fl_oe_n_o,
  input wire logic                       fl_we_n_o,
  input wire logic                       fl_reset_n_o,
  input wire logic                       fl_dq_oe_o,
  input wire logic                       fl_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take_rd;
    req_valid_i && req_ready_o && req_op_i == 2'h0;
  endsequence
  sequence s_bad_cmd;
    req_valid_i && req_ready_o && req_op_i == 2'h1 &&
    ((prog_running_i && !(req_wdata_i[7:0] inside {8'h51, 8'h70, 8'hB0})) ||
     (erase_running_i && !(req_wdata_i[7:0] inside {8'h70, 8'h80})));
  endsequence
  property p_read_lat; s_take_rd |-> ##3 rsp_valid_o; endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  property p_read_pins; rsp_valid_o |-> $past(!fl_ce_n_o && !fl_oe_n_o); endproperty
  a_read_pins: assert property (p_read_pins) else $error("read without strobes");
  property p_we_data; !fl_we_n_o |-> fl_dq_oe_o && !fl_ce_n_o && fl_oe_n_o; endproperty
  a_we_data: assert property (p_we_data) else $error("write strobe misdriven");
  property p_drop; s_bad_cmd |-> ##1 rsp_dropped_o; endproperty
  a_drop: assert property (p_drop) else $error("command not refused");
  property p_rst_pulse;
    $fell(fl_reset_n_o) |-> (!fl_reset_n_o && !req_ready_o)[*5] ##1 !req_ready_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse wrong");
  property p_busy_hi; (!fl_ready_i)[*6] |-> busy_o; endproperty
  a_busy_hi: assert property (p_busy_hi) else $error("busy not shown");
  property p_busy_lo; fl_ready_i[*6] |-> !busy_o; endproperty
  a_busy_lo: assert property (p_busy_lo) else $error("busy stuck");
endmodule
bind nfh_host nfh_host_chk u_chk (.ref_clk_i, .rst_i, .req_valid_i, .req_ready_o,
  .req_op_i, .req_wdata_i, .prog_running_i, .erase_running_i, .rsp_valid_o,
  .rsp_dropped_o, .busy_o, .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o, .fl_reset_n_o,
  .fl_dq_oe_o, .fl_ready_i);

// ---- dv/nfh_flash_model.sv ----
/* flash partner model: word array, program by and, erase by low byte 30, busy pin.
   assumes word addresses and uses the host clock to time the routine and to hold the last read word. */
module nfh_flash_model (
  input  wire logic        clk_i,
  input  wire logic [25:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic             ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [int];
  logic [15:0] last = 16'hFFFF;
  logic [25:0] pa;
  logic [15:0] pd;
  int          cnt = 0;
  function automatic logic [15:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  // deselected bus shows the inverse of the last value
  always_comb dq_o = (!ce_n_i && !oe_n_i) ? rd(int'(addr_i)) : ~last;
  assign ready_o = (cnt == 0);
  always @(posedge clk_i) if (!ce_n_i && !oe_n_i) last <= rd(int'(addr_i));
  // writes while a routine runs are ignored
  always @(posedge we_n_i) if (!ce_n_i && reset_n_i && cnt == 0) begin
    pa = addr_i;
    pd = dq_i;
    cnt = 20;
  end
  always @(posedge clk_i) begin
    if (!reset_n_i) cnt <= 0;
    else if (cnt == 1) begin
      cnt <= 0;
      if (pd[7:0] == 8'h30) begin
        foreach (mem[a]) if ((a >> 16) == (pa >> 16)) mem[a] = 16'hFFFF;
      end else mem[int'(pa)] = rd(int'(pa)) & pd;
    end
    else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

// ---- dv/nfh_host_tb.sv ----
/* testbench for nfh_host: reads, programs, erase, reset abort, command filtering.
   assumes the flash model of this folder and a 10 MHz clock. */
module nfh_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, v = 0, pr = 0, er = 0, dr;
  logic [1:0]  op = 0;
  logic [25:0] ad = 0, fa;
  logic [15:0] wd = 0, rdat, mq, fq;
  logic        rdy, rv, drp, bsy, ce, oe, we, rn, doe, frdy;
  int          failures = 0, n_checks = 0, cyc = 0;
  logic [0:9]  ex = 10'b0001110101;
  logic [7:0]  cd [5] = '{8'h51, 8'h70, 8'hB0, 8'h80, 8'h00};
  initial forever #50 clk = ~clk;
  nfh_host #(.RECOV_CYCLES(3), .SUSPEND_GAP(8)) dut (.ref_clk_i(clk), .rst_i(rst),
    .req_valid_i(v), .req_ready_o(rdy), .req_op_i(op), .req_addr_i(ad), .req_wdata_i(wd),
    .prog_running_i(pr), .erase_running_i(er), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
    .rsp_dropped_o(drp), .busy_o(bsy), .fl_addr_o(fa), .fl_ce_n_o(ce), .fl_oe_n_o(oe),
    .fl_we_n_o(we), .fl_reset_n_o(rn), .fl_dq_i(doe ? fq : mq), .fl_dq_o(fq),
    .fl_dq_oe_o(doe), .fl_ready_i(frdy));
  nfh_flash_model fm (.clk_i(clk), .addr_i(fa), .ce_n_i(ce), .oe_n_i(oe), .we_n_i(we),
    .reset_n_i(rn), .dq_i(fq), .dq_o(mq), .ready_o(frdy));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic req(input logic [1:0] o, input logic [25:0] a, input logic [15:0] d);
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    v = 1;
    op = o;
    ad = a;
    wd = d;
    @(negedge clk);
    v = 0;
    // the refusal pulse stands only in the cycle after the taking edge
    dr = drp;
    @(posedge clk) #1;
  endtask
  task automatic rdw(input logic [25:0] a, input logic [15:0] e);
    req(2'h0, a, 16'h0000);
    for (int i = 0; i < 8 && rv !== 1'b1; i++) @(posedge clk) #1;
    chk({15'h0, rv}, 16'h0001);
    chk(rdat, e);
  endtask
  task automatic wait_idle;
    repeat (6) @(posedge clk);
    chk({15'h0, bsy}, 16'h0001);
    for (int i = 0; i < 60 && bsy !== 1'b0; i++) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 0;
    req(2'h1, 26'h10, 16'h00F0);
    wait_idle();
    rdw(26'h10, 16'h00F0);
    req(2'h1, 26'h10, 16'h0F3C);
    wait_idle();
    rdw(26'h10, 16'h0030);
    rdw(26'h11, 16'hFFFF);
    rdw(26'h20, 16'hFFFF);
    $display("program and read done");
    req(2'h1, 26'h10, 16'h0030);
    wait_idle();
    rdw(26'h10, 16'hFFFF);
    $display("erase done");
    req(2'h1, 26'h200, 16'h0000);
    repeat (6) @(posedge clk);
    req(2'h2, 26'h0, 16'h0000);
    rdw(26'h200, 16'hFFFF);
    chk({15'h0, bsy}, 16'h0000);
    $display("reset abort done");
    req(2'h1, 26'h100, 16'h0000);
    chk({15'h0, dr}, 16'h0000);
    req(2'h1, 26'h100, 16'h0051);
    chk({15'h0, dr}, 16'h0001);
    repeat (12) @(posedge clk);
    req(2'h1, 26'h100, 16'h0051);
    chk({15'h0, dr}, 16'h0000);
    $display("suspend gap done");
    req(2'h3, 26'h100, 16'h0000);
    chk({15'h0, dr}, 16'h0001);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      pr = (k < 5);
      er = (k >= 5);
      req(2'h1, 26'h100, {8'h00, cd[k % 5]});
      chk({15'h0, dr}, {15'h0, ex[k]});
    end
    $display("command filter done");
    conclude();
  end
endmodule
